// File: ccic_pkg.sv
// package for the calibration and interrupt configuration register bank
// assumes a 16-bit register port with word addresses from the serial host port
package ccic_pkg;
    localparam logic [9:0]  ADDR_CTRL  = 10'h002;
    localparam logic [9:0]  ADDR_LEVEL = 10'h003;
    localparam logic [9:0]  ADDR_RECAL = 10'h004;
    localparam logic [9:0]  ADDR_LOWEN = 10'h005;
    localparam int          NUM_STEPS  = 12;
    localparam int          LOWEN_BITS = 7;
    localparam logic [3:0]  SKIP_MAX   = 4'hB;
    localparam logic [3:0]  SKIP_RST   = 4'h0;
    localparam logic [3:0]  FP_PER_RST = 4'hF;
    localparam logic [3:0]  LP_PER_RST = 4'hF;
    localparam logic [1:0]  TMO_RST    = 2'h0;
    localparam logic [7:0]  LVL_RST    = 8'h40;
    localparam logic [5:0]  RATE_RST   = 6'h01;
    localparam logic [1:0]  SLOW_RST   = 2'h0;
    localparam logic [9:0]  FPR_RST    = 10'h3FF;
    localparam logic [5:0]  LPR_RST    = 6'h3F;
    localparam logic [6:0]  LOWEN_RST  = 7'h00;
    localparam int          FORCE_BIT  = 14;
    localparam int          RESTART_BIT = 15;

    typedef struct packed {
        logic       restart;
        logic       force_cal;
        logic [1:0] sleep_timeout_select;
        logic [3:0] low_power_near_period;
        logic [3:0] full_power_near_period;
        logic [3:0] fast_filter_skip_count;
    } ccic_ctrl_type;

    typedef struct packed {
        logic [1:0] slow_filter_level;
        logic [5:0] detect_rate;
        logic [7:0] near_recal_level;
    } ccic_level_type;

    typedef struct packed {
        logic [5:0] low_power_recal_time;
        logic [9:0] full_power_recal_time;
    } ccic_recal_type;
endpackage

// File: ccic_regs.sv
// calibration/proximity configuration and low-threshold interrupt enables
// assumes reg_wr/reg_rd strobes one cycle long, synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - skip field bits 3:0, code N skips N+1 conversions, max 1011, reset 0
// - full-power proximity period bits 7:4, reset all ones
// - low-power proximity period bits 11:8, reset all ones, timeout base
// - timeout is low-power period times 1.25, 1.5, 1.75 or 2 by bits 13:12
// - bit 14 set forces every conversion step to recalibrate
// - bit 15 restarts the sequence at the first step, then self-clears
// - level 7:0 reset 64, rate 13:8 reset 1, slow filter 15:14 reset 0
// - full-power recalibration time bits 9:0, reset 3FF
// - low-power recalibration time bits 15:10, reset 3F
// - low enable bit n lets step n low exceedance assert the interrupt
// - sequence has at most twelve steps numbered from zero
module ccic_regs
    import ccic_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  soft_reset,
    // register port
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [9:0]            reg_addr,
    input  wire logic [15:0]           reg_wdata,
    output logic      [15:0]           reg_rdata,
    output logic                       reg_hit,
    // datapath status
    input  wire logic [NUM_STEPS-1:0]  step_low_exceeded,
    // configuration out
    output ccic_ctrl_type              ctrl,
    output ccic_level_type             level,
    output ccic_recal_type             recal,
    output logic      [LOWEN_BITS-1:0] low_irq_enable,
    output logic      [4:0]            skip_conversions,
    output logic      [6:0]            sleep_timeout_quarters,
    output logic                       sequence_restart,
    output logic                       force_recal,
    output logic                       low_irq
);
    ccic_ctrl_type               ctrl_reg;
    ccic_ctrl_type               ctrl_next;
    ccic_level_type              level_reg;
    ccic_level_type              level_next;
    ccic_recal_type              recal_reg;
    ccic_recal_type              recal_next;
    logic      [LOWEN_BITS-1:0]  lowen_reg;
    logic      [LOWEN_BITS-1:0]  lowen_next;
    logic      [15:0]            rdata_reg;
    logic      [15:0]            rdata_next;
    logic                        irq_reg;
    logic                        irq_next;
    logic      [4:0]             skip_reg;
    logic      [4:0]             skip_next;
    logic      [6:0]             tmo_reg;
    logic      [6:0]             tmo_next;

    // derived outputs while in reset
    localparam logic [4:0] SKIP_TOTAL_RST = 5'(SKIP_RST) + 5'h01;
    localparam logic [6:0] TMO_QTR_RST    = 7'(7'(LP_PER_RST) * (7'(TMO_RST) + 7'h05));

    function automatic logic wr_to(input logic [9:0] a);
        return reg_wr && (reg_addr == a);
    endfunction

    function automatic ccic_ctrl_type ctrl_defaults();
        ccic_ctrl_type c;
        c.restart                = 1'b0;
        c.force_cal              = 1'b0;
        c.sleep_timeout_select   = TMO_RST;
        c.low_power_near_period  = LP_PER_RST;
        c.full_power_near_period = FP_PER_RST;
        c.fast_filter_skip_count = SKIP_RST;
        return c;
    endfunction

    function automatic ccic_level_type level_defaults();
        ccic_level_type l;
        l.slow_filter_level = SLOW_RST;
        l.detect_rate       = RATE_RST;
        l.near_recal_level  = LVL_RST;
        return l;
    endfunction

    function automatic ccic_recal_type recal_defaults();
        ccic_recal_type r;
        r.low_power_recal_time  = LPR_RST;
        r.full_power_recal_time = FPR_RST;
        return r;
    endfunction

    // word addresses of this bank
    function automatic logic mapped(input logic [9:0] a);
        return (a >= ADDR_CTRL) && (a <= ADDR_LOWEN);
    endfunction

    // codes past the last step clamp to the longest legal skip
    function automatic logic [3:0] clamp_skip(input logic [3:0] code);
        return (code > SKIP_MAX) ? SKIP_MAX : code;
    endfunction

    // skip code N means N+1 conversions skipped
    function automatic logic [4:0] skip_total(input logic [3:0] code);
        return {1'b0, code} + 5'h01;
    endfunction

    // timeout in quarter periods: period * (5 + select), at most 120
    function automatic logic [6:0] timeout_quarters(input logic [3:0] period,
                                                    input logic [1:0] sel);
        return 7'({3'b000, period} * ({5'h00, sel} + 7'h05));
    endfunction

    // control word: writes, skip clamp, self-clearing restart
    always_comb
    begin
        ctrl_next         = ctrl_reg;
        ctrl_next.restart = 1'b0;
        if (soft_reset)
        begin
            ctrl_next = ctrl_defaults();
        end
        else if (wr_to(ADDR_CTRL))
        begin
            ctrl_next = ccic_ctrl_type'(reg_wdata);
            ctrl_next.fast_filter_skip_count = clamp_skip(reg_wdata[3:0]);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= ctrl_defaults();
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // proximity level, rate and slow filter word
    always_comb
    begin
        level_next = level_reg;
        if (soft_reset)
        begin
            level_next = level_defaults();
        end
        else if (wr_to(ADDR_LEVEL))
        begin
            level_next = ccic_level_type'(reg_wdata);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_reg <= level_defaults();
        end
        else
        begin
            level_reg <= level_next;
        end
    end

    // proximity recalibration times word
    always_comb
    begin
        recal_next = recal_reg;
        if (soft_reset)
        begin
            recal_next = recal_defaults();
        end
        else if (wr_to(ADDR_RECAL))
        begin
            recal_next = ccic_recal_type'(reg_wdata);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            recal_reg <= recal_defaults();
        end
        else
        begin
            recal_reg <= recal_next;
        end
    end

    // low enables; bits 15:7 are not stored
    always_comb
    begin
        lowen_next = lowen_reg;
        if (soft_reset)
        begin
            lowen_next = LOWEN_RST;
        end
        else if (wr_to(ADDR_LOWEN))
        begin
            lowen_next = reg_wdata[LOWEN_BITS-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lowen_reg <= LOWEN_RST;
        end
        else
        begin
            lowen_reg <= lowen_next;
        end
    end

    // derived values follow the control word in the same cycle
    always_comb
    begin
        skip_next = skip_total(ctrl_next.fast_filter_skip_count);
        tmo_next  = timeout_quarters(ctrl_next.low_power_near_period,
                                     ctrl_next.sleep_timeout_select);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            skip_reg <= SKIP_TOTAL_RST;
            tmo_reg  <= TMO_QTR_RST;
        end
        else
        begin
            skip_reg <= skip_next;
            tmo_reg  <= tmo_next;
        end
    end

    // read back, held until the next read
    always_comb
    begin
        rdata_next = rdata_reg;
        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_CTRL:  rdata_next = {1'b0, 15'(ctrl_reg)};
                ADDR_LEVEL: rdata_next = 16'(level_reg);
                ADDR_RECAL: rdata_next = 16'(recal_reg);
                ADDR_LOWEN: rdata_next = {9'h000, lowen_reg};
                default:    rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= 16'h0000;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // steps 7 and up have no enable here and stay masked
    always_comb
    begin
        irq_next = |(step_low_exceeded[LOWEN_BITS-1:0] & lowen_reg);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_next;
        end
    end

    // outputs
    assign reg_hit   = (reg_rd || reg_wr) && mapped(reg_addr);
    assign reg_rdata = rdata_reg;
    assign low_irq   = irq_reg;
    assign ctrl      = ctrl_reg;
    assign level     = level_reg;
    assign recal     = recal_reg;
    assign low_irq_enable   = lowen_reg;
    assign sequence_restart = ctrl_reg.restart;
    assign force_recal      = ctrl_reg.force_cal;
    assign skip_conversions = skip_reg;
    assign sleep_timeout_quarters = tmo_reg;
endmodule
`default_nettype wire

// File: ccic_regs_props.sv
// assertions on the configuration register bank ports
// assumes one clock domain, bound to ccic_regs
`timescale 1ns/1ps
`default_nettype none
module ccic_regs_props
    import ccic_pkg::*;
(
    // clock, reset, host side
    input wire logic                  mclk,
    input wire logic                  rst_n,
    input wire logic                  soft_reset,
    input wire logic                  reg_wr,
    input wire logic [9:0]            reg_addr,
    input wire logic [15:0]           reg_wdata,
    // outputs and status
    input wire logic [NUM_STEPS-1:0]  step_low_exceeded,
    input wire ccic_ctrl_type         ctrl,
    input wire ccic_level_type        level,
    input wire ccic_recal_type        recal,
    input wire logic [LOWEN_BITS-1:0] low_irq_enable,
    input wire logic [4:0]            skip_conversions,
    input wire logic [6:0]            sleep_timeout_quarters,
    input wire logic                  sequence_restart,
    input wire logic                  force_recal,
    input wire logic                  low_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire logic wr_ok = reg_wr && !soft_reset;

    skip_count_a: assert property (skip_conversions == 5'(ctrl.fast_filter_skip_count) + 5'h01)
        else $error("skip count wrong");
    skip_limit_a: assert property (ctrl.fast_filter_skip_count <= SKIP_MAX)
        else $error("skip code above limit");
    sleep_timeout_a: assert property (sleep_timeout_quarters ==
        7'(10'(ctrl.low_power_near_period) * (10'h005 + 10'(ctrl.sleep_timeout_select))))
        else $error("timeout wrong");
    force_follow_a: assert property (force_recal == ctrl.force_cal)
        else $error("force bit not passed out");
    restart_pulse_a: assert property (wr_ok && reg_addr == ADDR_CTRL && reg_wdata[15]
        |=> sequence_restart ##1 !sequence_restart) else $error("restart pulse wrong");
    ctrl_readback_a: assert property (wr_ok && reg_addr == ADDR_CTRL &&
        reg_wdata[3:0] <= SKIP_MAX |=> ctrl[14:0] == $past(reg_wdata[14:0]))
        else $error("control write lost");
    level_recal_a: assert property (wr_ok && (reg_addr == ADDR_LEVEL ||
        reg_addr == ADDR_RECAL) |=>
        ($past(reg_addr) == ADDR_LEVEL ? 16'(level) : 16'(recal)) == $past(reg_wdata))
        else $error("level or recal write lost");
    irq_or_a: assert property (!soft_reset |=> low_irq ==
        $past(|(step_low_exceeded[LOWEN_BITS-1:0] & low_irq_enable))) else $error("irq wrong");
    soft_default_a: assert property (soft_reset |=> ctrl == 16'h0FF0 &&
        level == 16'h0140 && recal == 16'hFFFF && low_irq_enable == 7'h00)
        else $error("soft reset defaults wrong");
endmodule
bind ccic_regs ccic_regs_props props_u (.mclk(mclk), .rst_n(rst_n), .soft_reset(soft_reset),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .step_low_exceeded(step_low_exceeded), .ctrl(ctrl), .level(level), .recal(recal),
    .low_irq_enable(low_irq_enable), .skip_conversions(skip_conversions),
    .sleep_timeout_quarters(sleep_timeout_quarters), .sequence_restart(sequence_restart),
    .force_recal(force_recal), .low_irq(low_irq));
`default_nettype wire

// File: testbench.sv
// self-checking bench for the configuration register bank
// assumes ccic_regs and its bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ccic_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, soft_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [9:0]  reg_addr = 10'h000;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [11:0] step_low_exceeded = 12'h000;
    logic [4:0]  skip_conversions;
    logic [6:0]  sleep_timeout_quarters;
    logic        sequence_restart, force_recal, low_irq, reg_hit;
    int          failures = 0, comparisons = 0;
    localparam logic [15:0] DFLT [4] = '{16'h0FF0, 16'h0140, 16'hFFFF, 16'h0000};

    ccic_regs dut_u (.mclk(mclk), .rst_n(rst_n), .soft_reset(soft_reset), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .step_low_exceeded(step_low_exceeded), .ctrl(), .level(), .recal(),
        .low_irq_enable(), .skip_conversions(skip_conversions), .force_recal(force_recal),
        .sleep_timeout_quarters(sleep_timeout_quarters), .sequence_restart(sequence_restart),
        .low_irq(low_irq));

    initial
    begin
        forever #5 mclk = ~mclk;
    end
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        tick();
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        tick();
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [15:0] exp);
        tick();
        {reg_rd, reg_addr} = {1'b1, a};
        tick();
        chk("hit", 16'(a >= ADDR_CTRL && a <= ADDR_LOWEN), 16'(reg_hit));
        reg_rd = 1'b0;
        chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask
    task automatic test_done();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++)
            rd(10'h002 + 10'(i), DFLT[i]);
        rd(10'h006, 16'h0000);
        wr(ADDR_CTRL, 16'h7ABB);
        chk("skip", 16'h000C, 16'(skip_conversions));
        chk("force", 16'h0001, 16'(force_recal));
        chk("timeout", 16'h0050, 16'(sleep_timeout_quarters));
        rd(ADDR_CTRL, 16'h7ABB);
        for (int s = 0; s < 4; s++)
        begin
            wr(ADDR_CTRL, 16'h0400 | 16'(s << 12));
            chk("timeout", 16'(20 + 4 * s), 16'(sleep_timeout_quarters));
        end
        wr(ADDR_CTRL, 16'h800F);
        chk("restart", 16'h0001, 16'(sequence_restart));
        tick();
        chk("restart", 16'h0000, 16'(sequence_restart));
        rd(ADDR_CTRL, 16'h000B);
        wr(ADDR_LEVEL, 16'hC2A5);
        rd(ADDR_LEVEL, 16'hC2A5);
        wr(ADDR_RECAL, 16'h5A3C);
        rd(ADDR_RECAL, 16'h5A3C);
        wr(ADDR_LOWEN, 16'hFFFF);
        rd(ADDR_LOWEN, 16'h007F);
        step_low_exceeded = 12'hF80;
        tick();
        chk("irq", 16'h0000, 16'(low_irq));
        step_low_exceeded = 12'h040;
        tick();
        chk("irq", 16'h0001, 16'(low_irq));
        wr(ADDR_LOWEN, 16'h003F);
        tick();
        chk("irq", 16'h0000, 16'(low_irq));
        soft_reset = 1'b1;
        tick();
        soft_reset = 1'b0;
        for (int i = 0; i < 4; i++)
            rd(ADDR_CTRL + 10'(i), DFLT[i]);
        chk("irq", 16'h0000, 16'(low_irq));
        test_done();
    end
    initial
    begin
        #20000;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
